// *** src/watch_pkg.sv ***
/*
 Constants, types and timing figures shared by the watch display controller
 and its push-button debouncer. Assumes a 20 MHz system clock and a 32,768 Hz
 crystal square wave arriving on a pin.
*/
// Contract
// - Standard view shows hour on digits one-two, minute on three-four.
// - Standard view flashes the colon at one hertz.
// - Display press in standard view shows month and date, colon off.
// - Month and date stay two seconds after display button release.
// - Two display presses within two seconds select seconds view, steady colon.
// - Holding set in seconds view clears and holds the seconds counter.
// - Seconds reset advances minute when seconds were thirty or more, else unchanged.
// - Display press in seconds view returns to standard view.
// - Set press in standard view enters alternating mode.
// - Alternating mode swaps time and date views every two seconds.
// - Alternating mode exits to standard only after five set presses.
// - Display press in alternating mode selects seconds view.
// - Both buttons are debounced within 62.5 milliseconds.
// - Crystal frequency is divided into second, minute, hour, date, month counts.
// - A 512 Hz divided clock drives the voltage doubler.
// - Duplexed LCD segments and two backplanes refresh at 32 Hz.
package watch_pkg;

    localparam int CLK_HZ = 20000000;
    localparam int DEB_TIME_US = 62500;
    localparam int DEB_CYCLES = DEB_TIME_US * (CLK_HZ / 1000000);
    localparam int VIEW_TIME_MS = 2000;
    localparam int VIEW_CYCLES = VIEW_TIME_MS * (CLK_HZ / 1000);
    localparam int DEB_W = 21;
    localparam int TMR_W = 26;

    localparam int PRESC_W = 15;
    localparam int DBL_BIT = 5;
    localparam int PLANE_BIT = 8;
    localparam int POL_BIT = 9;
    localparam int COLON_BIT = 14;

    localparam int SEG_PINS = 12;
    localparam int SEG_NUM = 24;

    localparam logic [5:0] SM_MAX = 6'h3B;
    localparam logic [5:0] SEC_ROUND = 6'h1E;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [4:0] HALF_DAY = 5'h0C;
    localparam logic [3:0] MONTH_MAX = 4'hC;
    localparam logic [3:0] MONTH_FEB = 4'h2;
    localparam logic [4:0] DAYS_LONG = 5'h1F;
    localparam logic [4:0] DAYS_SHORT = 5'h1E;
    localparam logic [4:0] DAYS_FEB = 5'h1C;
    localparam logic [4:0] DAYS_LEAP = 5'h1D;
    localparam logic [2:0] ALT_EXIT_PRESSES = 3'h5;

    localparam logic [5:0] RST_SEC = 6'h00;
    localparam logic [5:0] RST_MIN = 6'h00;
    localparam logic [4:0] RST_HOUR = 5'h0C;
    localparam logic [4:0] RST_DATE = 5'h01;
    localparam logic [3:0] RST_MONTH = 4'h1;
    localparam logic [1:0] RST_YEAR = 2'h0;

    typedef enum logic [1:0] {
        ST_STD = 2'b00,
        ST_MD = 2'b01,
        ST_SEC = 2'b10,
        ST_ALT = 2'b11
    } mode_t;

    typedef struct packed {
        logic one;
        logic blank12;
        logic [3:0] d2;
        logic [3:0] d3;
        logic [3:0] d4;
        logic colon;
    } disp_t;

    typedef struct packed {
        logic level;
        logic press;
    } button_t;

endpackage

// *** src/button_debounce.sv ***
/*
 Push-button debouncer: two-flop synchroniser, then a stability counter.
 Assumes a raw pin, active high, asynchronous to the clock.
*/
`timescale 1ns/100ps
`default_nettype none
module button_debounce
    import watch_pkg::*;
#(
    parameter int CYCLES = DEB_CYCLES
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic pin,
    output var button_t btn
);

    localparam logic [DEB_W-1:0] LAST = DEB_W'(CYCLES - 1);

    logic s1_q;
    logic s2_q;
    logic level_q;
    logic press_q;
    logic [DEB_W-1:0] cnt_q;

    always_ff @(posedge clock)
    begin
        s1_q <= pin;
        s2_q <= s1_q;
    end

    // A level is taken only after it has held for the whole interval.
    always_ff @(posedge clock)
    begin
        if (sys_rst || s2_q == level_q)
            cnt_q <= '0;
        else if (cnt_q != LAST)
            cnt_q <= cnt_q + 1'b1;
        else
            cnt_q <= '0;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            level_q <= 1'b0;
            press_q <= 1'b0;
        end
        else
        begin
            press_q <= (cnt_q == LAST) && s2_q && !level_q;
            if (cnt_q == LAST)
                level_q <= s2_q;
        end
    end

    assign btn = '{level: level_q, press: press_q};

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    deb_settle_a: assert property ($changed(level_q) |-> $past(cnt_q) == LAST)
        else $error("Debounced level moved before the interval ran out.");
    deb_press_a: assert property (press_q |-> level_q && !$past(level_q))
        else $error("Press pulse without a fresh debounced rise.");

endmodule
`default_nettype wire

// *** src/watch_display_mode_controller.sv ***
/*
 Timekeeping, calendar, display-mode control and duplexed LCD drive for a
 3.5-digit watch. Assumes a 32,768 Hz crystal square wave on xtal_clk and two
 active-high push buttons; all pins are asynchronous to clock.
*/
`timescale 1ns/100ps
`default_nettype none
module watch_display_mode_controller
    import watch_pkg::*;
#(
    parameter int DEB_CNT = DEB_CYCLES,
    parameter int VIEW_CNT = VIEW_CYCLES
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic xtal_clk,
    input wire logic disp_btn,
    input wire logic set_btn,
    output logic [SEG_PINS-1:0] seg_out,
    output logic [1:0] bp_out,
    output logic doubler_out,
    output var mode_t mode_out,
    output var disp_t disp_out
);

    localparam logic [TMR_W-1:0] VIEW_LAST = TMR_W'(VIEW_CNT - 1);

    logic xs1_q;
    logic xs2_q;
    logic xs3_q;
    logic xedge;
    logic sec_tick;
    logic [PRESC_W-1:0] presc_q;
    button_t dbtn;
    button_t sbtn;
    mode_t mode_q;
    logic [TMR_W-1:0] win_q;
    logic [TMR_W-1:0] hold_q;
    logic alt_view_q;
    logic [2:0] sets_q;
    logic [5:0] sec_q;
    logic [5:0] min_q;
    logic [4:0] hour_q;
    logic [4:0] date_q;
    logic [3:0] month_q;
    logic [1:0] year_q;
    logic sec_hold;
    logic round_up;
    logic min_inc;
    logic hour_inc;
    logic day_inc;
    logic [4:0] month_len;
    logic [4:0] hour12;
    logic view_date;
    disp_t disp_d;
    disp_t disp_q;
    logic [SEG_NUM-1:0] seg_on;
    logic [SEG_PINS-1:0] seg_q;
    logic [1:0] bp_q;
    logic doubler_q;

    function automatic logic [7:0] to_bcd(input logic [5:0] v);
        logic [3:0] t;
        logic [5:0] r;
        t = 4'h0;
        r = v;
        for (int i = 0; i < 5; i++)
        begin
            if (r >= 6'h0A)
            begin
                r = r - 6'h0A;
                t = t + 4'h1;
            end
        end
        return {t, r[3:0]};
    endfunction

    function automatic logic [6:0] seg7(input logic [3:0] v);
        case (v)
            4'h0: return 7'h3F;
            4'h1: return 7'h06;
            4'h2: return 7'h5B;
            4'h3: return 7'h4F;
            4'h4: return 7'h66;
            4'h5: return 7'h6D;
            4'h6: return 7'h7D;
            4'h7: return 7'h07;
            4'h8: return 7'h7F;
            4'h9: return 7'h6F;
            default: return 7'h00;
        endcase
    endfunction

    button_debounce #(.CYCLES(DEB_CNT)) u_disp_deb (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin(disp_btn),
        .btn(dbtn)
    );

    button_debounce #(.CYCLES(DEB_CNT)) u_set_deb (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin(set_btn),
        .btn(sbtn)
    );

    // The crystal is far slower than clock, so its rising edge is sampled.
    always_ff @(posedge clock)
    begin
        xs1_q <= xtal_clk;
        xs2_q <= xs1_q;
        xs3_q <= xs2_q;
    end

    assign xedge = xs2_q && !xs3_q;
    assign sec_tick = xedge && (presc_q == '1);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            presc_q <= '0;
        else if (xedge)
            presc_q <= presc_q + 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            mode_q <= ST_STD;
        else
        begin
            case (mode_q)
                ST_STD:
                begin
                    if (dbtn.press)
                        mode_q <= ST_MD;
                    else if (sbtn.press)
                        mode_q <= ST_ALT;
                end
                ST_MD:
                begin
                    if (dbtn.press && win_q < VIEW_LAST)
                        mode_q <= ST_SEC;
                    else if (!dbtn.level && hold_q == VIEW_LAST)
                        mode_q <= ST_STD;
                end
                ST_SEC:
                begin
                    if (dbtn.press)
                        mode_q <= ST_STD;
                end
                ST_ALT:
                begin
                    if (dbtn.press)
                        mode_q <= ST_SEC;
                    else if (sbtn.press && sets_q == ALT_EXIT_PRESSES - 3'h1)
                        mode_q <= ST_STD;
                end
                default: mode_q <= ST_STD;
            endcase
        end
    end

    // A late press after the window closed starts a fresh window.
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            win_q <= VIEW_LAST;
        else if (dbtn.press && (mode_q == ST_STD || (mode_q == ST_MD && win_q == VIEW_LAST)))
            win_q <= '0;
        else if (win_q != VIEW_LAST)
            win_q <= win_q + 1'b1;
    end

    // One timer serves both the release hold and the alternating period.
    always_ff @(posedge clock)
    begin
        if (sys_rst || mode_q == ST_STD || mode_q == ST_SEC)
            hold_q <= '0;
        else if (mode_q == ST_MD && dbtn.level)
            hold_q <= '0;
        else if (hold_q == VIEW_LAST)
            hold_q <= '0;
        else
            hold_q <= hold_q + 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst || mode_q != ST_ALT)
            alt_view_q <= 1'b0;
        else if (hold_q == VIEW_LAST)
            alt_view_q <= !alt_view_q;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst || mode_q != ST_ALT)
            sets_q <= 3'h0;
        else if (sbtn.press)
            sets_q <= sets_q + 3'h1;
    end

    assign sec_hold = (mode_q == ST_SEC) && sbtn.level;
    assign round_up = (mode_q == ST_SEC) && sbtn.press && (sec_q >= SEC_ROUND);
    assign min_inc = round_up || (sec_tick && !sec_hold && sec_q == SM_MAX);
    assign hour_inc = min_inc && (min_q == SM_MAX);
    assign day_inc = hour_inc && (hour_q == HOUR_MAX);

    always_comb
    begin
        case (month_q)
            MONTH_FEB: month_len = (year_q == 2'h0) ? DAYS_LEAP : DAYS_FEB;
            4'h4, 4'h6, 4'h9, 4'hB: month_len = DAYS_SHORT;
            default: month_len = DAYS_LONG;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            sec_q <= RST_SEC;
        else if (sec_hold)
            sec_q <= 6'h00;
        else if (sec_tick)
            sec_q <= (sec_q == SM_MAX) ? 6'h00 : sec_q + 6'h01;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            min_q <= RST_MIN;
        else if (min_inc)
            min_q <= (min_q == SM_MAX) ? 6'h00 : min_q + 6'h01;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            hour_q <= RST_HOUR;
        else if (hour_inc)
            hour_q <= (hour_q == HOUR_MAX) ? 5'h00 : hour_q + 5'h01;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            date_q <= RST_DATE;
            month_q <= RST_MONTH;
            year_q <= RST_YEAR;
        end
        else if (day_inc)
        begin
            if (date_q >= month_len)
            begin
                date_q <= 5'h01;
                if (month_q == MONTH_MAX)
                begin
                    month_q <= 4'h1;
                    year_q <= year_q + 2'h1;
                end
                else
                    month_q <= month_q + 4'h1;
            end
            else
                date_q <= date_q + 5'h01;
        end
    end

    assign hour12 = (hour_q == 5'h00) ? HALF_DAY :
        (hour_q > HALF_DAY) ? hour_q - HALF_DAY : hour_q;
    assign view_date = (mode_q == ST_MD) || (mode_q == ST_ALT && alt_view_q);

    always_comb
    begin
        disp_d = '0;
        if (mode_q == ST_SEC)
        begin
            disp_d.blank12 = 1'b1;
            {disp_d.d3, disp_d.d4} = to_bcd(sec_q);
            disp_d.colon = 1'b1;
        end
        else if (view_date)
        begin
            disp_d.one = month_q >= 4'hA;
            disp_d.d2 = 4'(to_bcd({2'b00, month_q}));
            {disp_d.d3, disp_d.d4} = to_bcd({1'b0, date_q});
        end
        else
        begin
            disp_d.one = hour12 >= 5'h0A;
            disp_d.d2 = 4'(to_bcd({1'b0, hour12}));
            {disp_d.d3, disp_d.d4} = to_bcd(min_q);
            disp_d.colon = presc_q[COLON_BIT];
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            disp_q <= '0;
        else
            disp_q <= disp_d;
    end

    assign seg_on = {disp_q.colon, disp_q.one, disp_q.one,
        disp_q.blank12 ? 7'h00 : seg7(disp_q.d2), seg7(disp_q.d3), seg7(disp_q.d4)};

    // Each segment pin serves two segments, one per backplane half-frame, and
    // polarity flips every frame so the glass sees no net DC.
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            bp_q <= 2'b00;
            seg_q <= '0;
            doubler_q <= 1'b0;
        end
        else
        begin
            doubler_q <= presc_q[DBL_BIT];
            bp_q[0] <= presc_q[PLANE_BIT] ? presc_q[POL_BIT] : !presc_q[POL_BIT];
            bp_q[1] <= presc_q[PLANE_BIT] ? !presc_q[POL_BIT] : presc_q[POL_BIT];
            for (int i = 0; i < SEG_PINS; i++)
                seg_q[i] <= seg_on[2 * i + int'(presc_q[PLANE_BIT])] ^ !presc_q[POL_BIT];
        end
    end

    assign seg_out = seg_q;
    assign bp_out = bp_q;
    assign doubler_out = doubler_q;
    assign mode_out = mode_q;
    assign disp_out = disp_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    std_to_md_a: assert property (mode_q == ST_STD && dbtn.press |=> mode_q == ST_MD ##1 !disp_q.colon)
        else $error("Display press in standard view did not show date with colon off.");
    std_to_alt_a: assert property (mode_q == ST_STD && !dbtn.press && sbtn.press |=> mode_q == ST_ALT)
        else $error("Set press in standard view did not enter alternating mode.");
    double_press_a: assert property (mode_q == ST_MD && dbtn.press && win_q < VIEW_LAST |=> mode_q == ST_SEC)
        else $error("Second press within the window did not select seconds view.");
    sec_view_a: assert property (mode_q == ST_SEC |=> disp_q.blank12 && disp_q.colon)
        else $error("Seconds view not blanked or colon not steady.");
    md_release_a: assert property (mode_q == ST_MD && !dbtn.level && hold_q == VIEW_LAST |=> mode_q == ST_STD)
        else $error("Date view not left after the release hold.");
    sec_hold_a: assert property (mode_q == ST_SEC && sbtn.level |=> sec_q == 6'h00)
        else $error("Seconds not held at zero while set is held.");
    round_up_a: assert property (mode_q == ST_SEC && sbtn.press && sec_q >= 6'h1E
        |=> min_q == $past(min_q) + 6'h01 || min_q == 6'h00)
        else $error("Minute not advanced on seconds reset at thirty or more.");
    round_keep_a: assert property (mode_q == ST_SEC && sbtn.press && sec_q < 6'h1E |=> $stable(min_q))
        else $error("Minute changed on seconds reset below thirty.");
    sec_exit_a: assert property (mode_q == ST_SEC && dbtn.press |=> mode_q == ST_STD)
        else $error("Display press in seconds view did not return to standard.");
    alt_to_sec_a: assert property (mode_q == ST_ALT && dbtn.press |=> mode_q == ST_SEC)
        else $error("Display press in alternating mode did not select seconds view.");
    alt_exit_a: assert property (mode_q == ST_ALT && !dbtn.press && sbtn.press
        |=> (mode_q == ST_STD) == ($past(sets_q) == 3'h4))
        else $error("Alternating mode left on the wrong set press count.");
    date_range_a: assert property (date_q != 5'h00 && date_q <= month_len)
        else $error("Date outside the month length.");

endmodule
`default_nettype wire

// *** test/watch_user_model.sv ***
/*
 Model of what faces the watch controller: the crystal square wave and the
 two push buttons pressed by a wearer. Assumes it shares the bench clock and
 changes every pin on that clock's falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module watch_user_model #(
    parameter int XT_HALF = 2
)
(
    input wire logic clock,
    output var logic xtal_clk,
    output var logic disp_btn,
    output var logic set_btn
);
    // The crystal runs far faster than real time so divider periods fit the run.
    initial
    begin
        xtal_clk = 1'b0;
        disp_btn = 1'b0;
        set_btn = 1'b0;
        forever
        begin
            repeat (XT_HALF) @(negedge clock);
            xtal_clk = ~xtal_clk;
        end
    end

    // Holds one button for hold cycles, then leaves it released for gap cycles.
    task automatic press(input logic which, input int hold, input int gap);
        @(negedge clock);
        if (which)
            set_btn = 1'b1;
        else
            disp_btn = 1'b1;
        repeat (hold) @(negedge clock);
        disp_btn = 1'b0;
        set_btn = 1'b0;
        repeat (gap) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
/*
 Self-checking bench for the watch display mode controller. Assumes short
 debounce and view counts and a crystal toggled every two bench cycles.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("Error at %0t ns: got %0h expected %0h", $time, (got), (exp)); \
        end \
    end
module tb_top
    import watch_pkg::*;
;
    localparam int DEB = 8;
    localparam int VIEW = 64;
    localparam int XT_HALF = 2;
    localparam int LIMIT = 20000;
    // Digit fields {one, blank12, d2, d3, d4}: noon 12:00 and January 1.
    localparam logic [13:0] TIME12 = 14'h2200;
    localparam logic [13:0] DATE11 = 14'h0101;
    localparam logic D = 1'b0;
    localparam logic S = 1'b1;

    logic clock;
    logic sys_rst;
    logic xtal_clk;
    logic disp_btn;
    logic set_btn;
    logic [SEG_PINS-1:0] seg_out;
    logic [1:0] bp_out;
    logic doubler_out;
    mode_t mode_out;
    disp_t disp_out;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;

    watch_user_model #(.XT_HALF(XT_HALF)) u_watch_user_model (
        .clock(clock),
        .xtal_clk(xtal_clk),
        .disp_btn(disp_btn),
        .set_btn(set_btn)
    );

    watch_display_mode_controller #(.DEB_CNT(DEB), .VIEW_CNT(VIEW)) u_watch_display_mode_controller (
        .clock(clock),
        .sys_rst(sys_rst),
        .xtal_clk(xtal_clk),
        .disp_btn(disp_btn),
        .set_btn(set_btn),
        .seg_out(seg_out),
        .bp_out(bp_out),
        .doubler_out(doubler_out),
        .mode_out(mode_out),
        .disp_out(disp_out)
    );

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            summarize();
        end
    end

    task automatic press(input logic which, input int hold, input int gap);
        u_watch_user_model.press(which, hold, gap);
    endtask

    // The colon is left out because it flashes in the time view.
    task automatic view(input logic [13:0] exp);
        `CHK({disp_out.one, disp_out.blank12, disp_out.d2, disp_out.d3, disp_out.d4}, exp)
    endtask

    function automatic logic pick(input int which);
        return (which != 0) ? bp_out[0] : doubler_out;
    endfunction

    // Counts bench cycles between two rising edges of the chosen output.
    task automatic rise_gap(input int which, output int gap);
        int n;
        int rises;
        logic p;
        logic c;
        rises = 0;
        gap = 0;
        p = pick(which);
        for (n = 0; n < 10000 && rises < 2; n++)
        begin
            @(negedge clock);
            c = pick(which);
            if (rises == 1)
                gap++;
            if (p === 1'b0 && c === 1'b1)
                rises++;
            p = c;
        end
    endtask

    task automatic t_reset();
        `CHK(mode_out, ST_STD)
        view(TIME12);
        $display("test reset_view done");
    endtask

    task automatic t_month_date();
        press(D, DEB + 5, 0);
        `CHK(mode_out, ST_MD)
        view(DATE11);
        `CHK(disp_out.colon, 1'b0)
        // In 01 01 pins 11, 10 and 2 carry two dark segments and pin 4 two lit ones.
        `CHK({seg_out[11], seg_out[2], seg_out[4]}, {{2{seg_out[10]}}, ~seg_out[10]})
        repeat (60) @(negedge clock);
        `CHK(mode_out, ST_MD)
        repeat (40) @(negedge clock);
        `CHK(mode_out, ST_STD)
        $display("test month_date done");
    endtask

    task automatic t_seconds();
        press(D, 16, 16);
        press(D, 16, 0);
        `CHK(mode_out, ST_SEC)
        `CHK({disp_out.one, disp_out.blank12, disp_out.colon}, 3'h3)
        press(S, 40, 16);
        `CHK(mode_out, ST_SEC)
        `CHK({disp_out.d3, disp_out.d4}, 8'h00)
        press(D, 16, 16);
        `CHK(mode_out, ST_STD)
        view(TIME12);
        $display("test seconds done");
    endtask

    task automatic t_alternate();
        int i;
        press(S, 16, 0);
        `CHK(mode_out, ST_ALT)
        repeat (16) @(negedge clock);
        view(TIME12);
        repeat (64) @(negedge clock);
        view(DATE11);
        `CHK(disp_out.colon, 1'b0)
        repeat (64) @(negedge clock);
        view(TIME12);
        for (i = 1; i <= 5; i++)
        begin
            press(S, 16, 16);
            `CHK(mode_out, (i < 5) ? ST_ALT : ST_STD)
        end
        press(S, 16, 16);
        press(D, 16, 16);
        `CHK(mode_out, ST_SEC)
        press(D, 16, 16);
        `CHK(mode_out, ST_STD)
        $display("test alternate done");
    endtask

    task automatic t_glitch();
        press(D, DEB - 3, 20);
        press(S, DEB - 3, 20);
        `CHK(mode_out, ST_STD)
        $display("test glitch done");
    endtask

    task automatic t_dividers();
        int gap;
        rise_gap(0, gap);
        `CHK(gap, 64 * 2 * XT_HALF)
        rise_gap(1, gap);
        `CHK(gap, 1024 * 2 * XT_HALF)
        `CHK(bp_out[1], ~bp_out[0])
        $display("test dividers done");
    endtask

    initial
    begin
        sys_rst = 1'b1;
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        repeat (2) @(negedge clock);
        t_reset();
        t_month_date();
        t_seconds();
        t_alternate();
        t_glitch();
        t_dividers();
        summarize();
    end
endmodule
`default_nettype wire
